// *** verilog/hdam_defs.vh ***
`ifndef HDAM_DEFS_VH
`define HDAM_DEFS_VH
// custom shape point count and quarter index
`define HDAM_POINTS 16
`define HDAM_QUARTER_LAST 3'd4
// coefficient reset values, 8-bit fraction of full scale
// 37.9 % ~ 97/256, 70.3 % ~ 180/256, 92.2 % ~ 236/256
`define HDAM_COEFF1_RST 8'h61
`define HDAM_COEFF2_RST 8'hB4
`define HDAM_COEFF3_RST 8'hEC
// full scale point 4 as coefficient
`define HDAM_COEFF_FULL 9'h100
// impedance field split: high part times 4 plus low part
`define HDAM_IMP_LOW_BITS 2
// amplitude loop current reduction shift
`define HDAM_AMP_LOOP_SHIFT 2
// event flag positions
`define HDAM_EV_SHORT 0
`define HDAM_EV_DONE 1
`define HDAM_EV_IMP 2
`define HDAM_EV_CNT 3
// mode codes
`define HDAM_MODE_DIRECT 2'h0
`define HDAM_MODE_PWM 2'h1
`define HDAM_MODE_RTMEM 2'h2
`define HDAM_MODE_ETMEM 2'h3
`endif

// *** verilog/hdam_fifo.v ***
`timescale 1ns/100ps
module hdam_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire MCLK,
  input wire ARST_N,
  // fill side
  input wire IN_VALID,
  output wire IN_READY,
  input wire [WIDTH-1:0] IN_DATA,
  // drain side
  output wire OUT_VALID,
  input wire OUT_READY,
  output reg [WIDTH-1:0] OUT_DATA,
  // level
  output wire FULL,
  output wire EMPTY
);
  localparam [AW:0] DEPTH_N = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  reg out_full;
  wire push;
  wire pop;
  wire load;
  assign FULL = (count == DEPTH_N);
  assign EMPTY = (count == {(AW+1){1'b0}});
  assign IN_READY = !FULL;
  assign push = IN_VALID && !FULL;
  assign OUT_VALID = out_full;
  assign load = !EMPTY && (!out_full || OUT_READY);
  assign pop = load;
  always @(posedge MCLK) begin
    if (push) begin
      mem[wr_ptr] <= IN_DATA;
    end
  end
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      out_full <= 1'b0;
      OUT_DATA <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
        OUT_DATA <= mem[rd_ptr];
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
      if (load) begin
        out_full <= 1'b1;
      end else if (OUT_READY) begin
        out_full <= 1'b0;
      end
    end
  end
endmodule // hdam_fifo

// *** verilog/hdam_core.v ***
`timescale 1ns/100ps
`include "hdam_defs.vh"
module hdam_core #(
  parameter PW = 16,
  parameter AMPW = 8,
  parameter DEPTH = 16
) (
  // clock and reset
  input wire MCLK,
  input wire ARST_N,
  // configuration
  input wire [1:0] INPUT_MODE,
  input wire SHAPE_GENERATOR_SELECT,
  input wire VI_FACTOR_HOLD,
  input wire RESISTANCE_CAL_DISABLE,
  input wire AMPLITUDE_LOOP_ENABLE,
  input wire EMBEDDED_MODE,
  input wire [PW-1:0] DRIVE_PERIOD_SETTING,
  input wire [AMPW-1:0] FULL_SCALE_CURRENT,
  input wire [AMPW-1:0] VOLT_TO_CURRENT_FACTOR_INIT,
  // coefficient writes
  input wire COEFF_WR,
  input wire [1:0] COEFF_SEL,
  input wire [7:0] COEFF_DATA,
  // playback
  input wire PLAY_REQ,
  input wire PLAY_STOP,
  // stream input: amplitude, period, frame period present
  input wire STREAM_VALID,
  output wire STREAM_READY,
  input wire [AMPW-1:0] STREAM_AMPLITUDE,
  input wire [PW-1:0] STREAM_PERIOD,
  input wire STREAM_HAS_PERIOD,
  // analog sense inputs from pins
  input wire SHORT_DETECT,
  input wire BEMF_HIGH,
  input wire [7:0] SENSE_IMPEDANCE,
  // events
  input wire [`HDAM_EV_CNT-1:0] EVENT_CLEAR,
  input wire [`HDAM_EV_CNT-1:0] EVENT_MASK_FIRST,
  input wire [`HDAM_EV_CNT-1:0] EVENT_MASK_SECOND,
  output reg [`HDAM_EV_CNT-1:0] EVENT_FLAGS,
  output wire EVENT_IRQ,
  // status
  output reg [5:0] IMPEDANCE_HIGH,
  output reg [1:0] IMPEDANCE_LOW,
  output reg [AMPW-1:0] VOLT_TO_CURRENT_FACTOR,
  output reg HALF_PERIOD_FLAG,
  output reg DRIVING,
  // drive output
  output reg [AMPW-1:0] DRIVE_LEVEL,
  output reg DRIVE_POLARITY,
  output reg LOOP_ENABLE
);
  localparam ST_IDLE = 3'b001;
  localparam ST_DRIVE = 3'b010;
  localparam ST_INACT = 3'b100;
  reg [2:0] state;
  reg [2:0] sh_s1, sh_s2;
  reg [7:0] imp_s1, imp_s2;
  reg [7:0] coeff1, coeff2, coeff3;
  reg [PW-1:0] period_cur;
  reg [PW-1:0] period_cnt;
  reg [3:0] point;
  reg [AMPW-1:0] amplitude;
  reg first_half;
  reg measured;
  reg hp_raw;
  reg hp_s1;
  wire short_s, bemf_s, play_s;
  wire [PW-1:0] period_sub;
  wire sub_tick;
  wire half_start;
  wire [`HDAM_EV_CNT-1:0] ev_set;
  wire fifo_valid;
  wire [AMPW+PW:0] fifo_data;
  wire skip_cal;
  wire [AMPW-1:0] level_raw;
  assign {short_s, bemf_s, play_s} = sh_s2;
  assign period_sub = period_cur >> 3;
  assign sub_tick = (period_cnt == {PW{1'b0}});
  assign half_start = sub_tick && (point[2:0] == 3'd7);
  assign skip_cal = VI_FACTOR_HOLD && RESISTANCE_CAL_DISABLE;
  // mirror point index into 0..4 within a quarter
  function [2:0] quarter_idx;
    input [3:0] p;
    begin
      if (p[2:0] <= `HDAM_QUARTER_LAST)
        quarter_idx = p[2:0];
      else
        quarter_idx = 3'd0 - p[2:0];
    end
  endfunction
  // scale amplitude by shape coefficient of a point
  function [AMPW-1:0] shape_scale;
    input [2:0] q;
    input [AMPW-1:0] a;
    input [7:0] c1, c2, c3;
    reg [8:0] c;
    reg [AMPW+8:0] prod;
    begin
      c = 9'h000;
      prod = {(AMPW+9){1'b0}};
      case (q)
        3'd1: c = {1'b0, c1};
        3'd2: c = {1'b0, c2};
        3'd3: c = {1'b0, c3};
        3'd4: c = `HDAM_COEFF_FULL;
        default: c = 9'h000;
      endcase
      prod = a * c;
      shape_scale = prod[AMPW+7:8];
    end
  endfunction
  //////////////////////////////////////////////////////////////////////////
  // input synchronisers
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sh_s1 <= 3'b000;
      sh_s2 <= 3'b000;
      imp_s1 <= 8'h00;
      imp_s2 <= 8'h00;
    end else begin
      sh_s1 <= {SHORT_DETECT, BEMF_HIGH, PLAY_REQ};
      sh_s2 <= sh_s1;
      imp_s1 <= SENSE_IMPEDANCE;
      imp_s2 <= imp_s1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // stream buffer
  hdam_fifo #(
    .WIDTH(AMPW + PW + 1),
    .DEPTH(DEPTH),
    .AW(4)
  ) u_fifo (
    .MCLK(MCLK),
    .ARST_N(ARST_N),
    .IN_VALID(STREAM_VALID),
    .IN_READY(STREAM_READY),
    .IN_DATA({STREAM_HAS_PERIOD, STREAM_PERIOD, STREAM_AMPLITUDE}),
    .OUT_VALID(fifo_valid),
    .OUT_READY(half_start),
    .OUT_DATA(fifo_data),
    .FULL(),
    .EMPTY()
  );
  //////////////////////////////////////////////////////////////////////////
  // coefficients
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      coeff1 <= `HDAM_COEFF1_RST;
      coeff2 <= `HDAM_COEFF2_RST;
      coeff3 <= `HDAM_COEFF3_RST;
    end else if (COEFF_WR) begin
      if (COEFF_SEL == 2'd1)
        coeff1 <= COEFF_DATA;
      else if (COEFF_SEL == 2'd2)
        coeff2 <= COEFF_DATA;
      else if (COEFF_SEL == 2'd3)
        coeff3 <= COEFF_DATA;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // playback state machine and point sequencer
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_IDLE;
      period_cur <= {PW{1'b0}};
      period_cnt <= {PW{1'b0}};
      point <= 4'h0;
      amplitude <= {AMPW{1'b0}};
      first_half <= 1'b0;
      measured <= 1'b0;
      hp_raw <= 1'b0;
      DRIVING <= 1'b0;
      LOOP_ENABLE <= 1'b0;
      DRIVE_POLARITY <= 1'b0;
      IMPEDANCE_HIGH <= 6'h00;
      IMPEDANCE_LOW <= 2'h0;
      VOLT_TO_CURRENT_FACTOR <= {AMPW{1'b0}};
    end else begin
      case (state)
        ST_IDLE: begin
          if (VOLT_TO_CURRENT_FACTOR == {AMPW{1'b0}})
            VOLT_TO_CURRENT_FACTOR <= VOLT_TO_CURRENT_FACTOR_INIT;
          if (play_s && !short_s) begin
            state <= ST_DRIVE;
            period_cur <= DRIVE_PERIOD_SETTING;
            period_cnt <= DRIVE_PERIOD_SETTING >> 3;
            point <= 4'h0;
            first_half <= 1'b1;
            measured <= skip_cal;
            hp_raw <= ~hp_raw;
            DRIVING <= 1'b1;
            LOOP_ENABLE <= 1'b1;
            DRIVE_POLARITY <= 1'b0;
          end
        end
        ST_DRIVE: begin
          if (short_s) begin
            DRIVING <= 1'b0;
            LOOP_ENABLE <= 1'b0;
            state <= ST_INACT;
          end else if (PLAY_STOP) begin
            DRIVING <= 1'b0;
            LOOP_ENABLE <= 1'b0;
            state <= ST_INACT;
          end else begin
            // one-shot impedance sample in first half-period
            if (first_half && !measured && point[2:0] == 3'd4) begin
              IMPEDANCE_HIGH <= imp_s2[7:2];
              IMPEDANCE_LOW <= imp_s2[1:0];
              VOLT_TO_CURRENT_FACTOR <= imp_s2;
              measured <= 1'b1;
            end
            if (sub_tick) begin
              period_cnt <= period_sub;
              point <= point + 4'h1;
              if (half_start) begin
                first_half <= 1'b0;
                DRIVE_POLARITY <= ~DRIVE_POLARITY;
                hp_raw <= ~hp_raw;
                if (fifo_valid) begin
                  amplitude <= fifo_data[AMPW-1:0];
                  if (INPUT_MODE == `HDAM_MODE_DIRECT ||
                      INPUT_MODE == `HDAM_MODE_PWM ||
                      fifo_data[AMPW+PW])
                    period_cur <= fifo_data[AMPW+PW-1:AMPW];
                  else
                    period_cur <= DRIVE_PERIOD_SETTING;
                end else begin
                  period_cur <= DRIVE_PERIOD_SETTING;
                end
              end
            end else begin
              period_cnt <= period_cnt - 1'b1;
            end
          end
        end
        ST_INACT: begin
          if (!play_s)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // output level
  assign level_raw = SHAPE_GENERATOR_SELECT ?
    shape_scale(quarter_idx(point), FULL_SCALE_CURRENT,
                coeff1, coeff2, coeff3) :
    FULL_SCALE_CURRENT;
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DRIVE_LEVEL <= {AMPW{1'b0}};
    end else if (state != ST_DRIVE) begin
      DRIVE_LEVEL <= {AMPW{1'b0}};
    end else if (AMPLITUDE_LOOP_ENABLE && bemf_s) begin
      DRIVE_LEVEL <= level_raw -
        (level_raw >> `HDAM_AMP_LOOP_SHIFT);
    end else begin
      DRIVE_LEVEL <= level_raw;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // events
  assign ev_set[`HDAM_EV_SHORT] = (state == ST_DRIVE) && short_s;
  assign ev_set[`HDAM_EV_DONE] = (state == ST_DRIVE) && PLAY_STOP;
  assign ev_set[`HDAM_EV_IMP] = (state == ST_DRIVE) && first_half &&
    !measured && (point[2:0] == 3'd4);
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      EVENT_FLAGS <= {`HDAM_EV_CNT{1'b0}};
    end else if (EMBEDDED_MODE && state == ST_INACT) begin
      EVENT_FLAGS <= ev_set;
    end else begin
      EVENT_FLAGS <= (EVENT_FLAGS & ~EVENT_CLEAR) | ev_set;
    end
  end
  assign EVENT_IRQ = |(EVENT_FLAGS & ~EVENT_MASK_FIRST &
    ~EVENT_MASK_SECOND);
  //////////////////////////////////////////////////////////////////////////
  // half-period flag toward the register side
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hp_s1 <= 1'b0;
      HALF_PERIOD_FLAG <= 1'b0;
    end else begin
      hp_s1 <= hp_raw;
      HALF_PERIOD_FLAG <= hp_s1;
    end
  end
endmodule // hdam_core

// *** bench/hdam_core_chk.sv ***
`timescale 1ns/100ps
module hdam_core_chk (
  // clock and reset
  input wire MCLK,
  input wire ARST_N,
  // configuration and pins
  input wire VI_FACTOR_HOLD,
  input wire RESISTANCE_CAL_DISABLE,
  input wire EMBEDDED_MODE,
  input wire SHORT_DETECT,
  // events
  input wire [2:0] EVENT_CLEAR,
  input wire [2:0] EVENT_MASK_FIRST,
  input wire [2:0] EVENT_MASK_SECOND,
  input wire [2:0] EVENT_FLAGS,
  input wire EVENT_IRQ,
  // status and drive
  input wire [5:0] IMPEDANCE_HIGH,
  input wire [1:0] IMPEDANCE_LOW,
  input wire HALF_PERIOD_FLAG,
  input wire DRIVING,
  input wire DRIVE_POLARITY,
  input wire LOOP_ENABLE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  short_stop_a: assert property (
    SHORT_DETECT |-> ##[1:4] (!DRIVING && !LOOP_ENABLE))
    else $error("short left drive on");
  irq_mask_a: assert property (
    EVENT_IRQ == |(EVENT_FLAGS & ~(EVENT_MASK_FIRST | EVENT_MASK_SECOND)))
    else $error("irq not masked flags");
  flag_clear_a: assert property (
    EVENT_FLAGS[2] && EVENT_CLEAR[2] && !DRIVING && !$past(DRIVING)
    |=> !EVENT_FLAGS[2]) else $error("flag not cleared");
  embed_clear_a: assert property (
    (EMBEDDED_MODE && !DRIVING && !SHORT_DETECT) [*4]
    |=> EVENT_FLAGS == 3'h0) else $error("embedded flags kept");
  half_flag_a: assert property (
    DRIVING && $past(DRIVING) && $changed(DRIVE_POLARITY)
    |-> ##2 $changed(HALF_PERIOD_FLAG)) else $error("half flag late");
  imp_first_a: assert property (
    $rose(EVENT_FLAGS[2]) |-> $past(DRIVING))
    else $error("measure while idle");
  imp_skip_a: assert property (
    VI_FACTOR_HOLD && RESISTANCE_CAL_DISABLE |=> !$rose(EVENT_FLAGS[2])
    && $stable(IMPEDANCE_HIGH) && $stable(IMPEDANCE_LOW))
    else $error("measure not skipped");
  imp_pub_a: assert property (
    $changed(IMPEDANCE_HIGH) || $changed(IMPEDANCE_LOW) |=> EVENT_FLAGS[2])
    else $error("publish without flag");
endmodule // hdam_core_chk
////////////////////////////////////////
bind hdam_core hdam_core_chk hdam_core_chk_i (.*);

// *** bench/hdam_host.sv ***
`timescale 1ns/100ps
module hdam_host (
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // word request
  input wire send,
  input wire has,
  input wire [15:0] per,
  // stream side
  input wire ready,
  output reg valid,
  output reg [7:0] amp,
  output reg [15:0] oper,
  output reg ohas
);
  // word held until taken, stale data inverted after
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      valid <= 1'b0;
      amp <= 8'h00;
      oper <= 16'h0000;
      ohas <= 1'b0;
    end else if (valid && ready) begin
      valid <= 1'b0;
      amp <= ~amp;
      oper <= ~oper;
      ohas <= ~ohas;
    end else if (send && !valid) begin
      valid <= 1'b1;
      amp <= 8'hFF;
      oper <= per;
      ohas <= has;
    end
  end
endmodule // hdam_host

// *** bench/haptic_drive_advanced_modes_bench.sv ***
`timescale 1ns/100ps
module haptic_drive_advanced_modes_bench;
  logic mclk = 1'b0, arst_n = 1'b0, shape = 1'b0, hold = 1'b0;
  logic rcd = 1'b0, ale = 1'b0, emb = 1'b0, cwr = 1'b0, req = 1'b0;
  logic stp = 1'b0, shrt = 1'b0, bemf = 1'b0, send = 1'b0, has = 1'b0;
  logic [1:0] mode = 2'h0, csel = 2'h0;
  logic [7:0] sense = 8'hA7, pk;
  logic [15:0] per = 16'h0010, dper = 16'h0010;
  logic [2:0] clr = 3'h0, mk1 = 3'h0, mk2 = 3'h0, flags;
  wire sv, sr, shas, irq, hpf, drv, pol, lpe;
  wire [7:0] samp, lvl, vif;
  wire [15:0] sper;
  wire [5:0] imph;
  wire [1:0] impl;
  logic [7:0] lv [0:7];
  logic [7:0] dc [1:3] = '{8'h61, 8'hB4, 8'hEC};
  int err_count = 0, n_compared = 0, cyc = 0, n, h;
  hdam_core hdam_core_i (.MCLK(mclk), .ARST_N(arst_n), .INPUT_MODE(mode),
    .SHAPE_GENERATOR_SELECT(shape), .VI_FACTOR_HOLD(hold),
    .RESISTANCE_CAL_DISABLE(rcd), .AMPLITUDE_LOOP_ENABLE(ale),
    .EMBEDDED_MODE(emb), .DRIVE_PERIOD_SETTING(dper),
    .FULL_SCALE_CURRENT(8'hC8), .VOLT_TO_CURRENT_FACTOR_INIT(8'h40),
    .COEFF_WR(cwr), .COEFF_SEL(csel), .COEFF_DATA(8'h00), .PLAY_REQ(req),
    .PLAY_STOP(stp), .STREAM_VALID(sv), .STREAM_READY(sr),
    .STREAM_AMPLITUDE(samp), .STREAM_PERIOD(sper), .STREAM_HAS_PERIOD(shas),
    .SHORT_DETECT(shrt), .BEMF_HIGH(bemf), .SENSE_IMPEDANCE(sense),
    .EVENT_CLEAR(clr), .EVENT_MASK_FIRST(mk1), .EVENT_MASK_SECOND(mk2),
    .EVENT_FLAGS(flags), .EVENT_IRQ(irq), .IMPEDANCE_HIGH(imph),
    .IMPEDANCE_LOW(impl), .VOLT_TO_CURRENT_FACTOR(vif),
    .HALF_PERIOD_FLAG(hpf),
    .DRIVING(drv), .DRIVE_LEVEL(lvl), .DRIVE_POLARITY(pol), .LOOP_ENABLE(lpe));
  hdam_host hdam_host_i (.mclk(mclk), .arst_n(arst_n), .send(send),
    .has(has), .per(per), .ready(sr), .valid(sv), .amp(samp), .oper(sper),
    .ohas(shas));
  ////////////////////////////////////////
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      close_out();
    end
  end
  task step(input int k = 1);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task close_out();
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function logic near(input logic [7:0] a, m, c);
    int e;
    e = m * c / 256;
    return a + 2 >= e && a <= e + 2;
  endfunction
  function logic [7:0] peak();
    peak = 8'h00;
    for (int k = 0; k < 8; k++) if (lv[k] > peak) peak = lv[k];
  endfunction
  task push(input int k);
    repeat (k) begin
      send = 1'b1;
      step();
      send = 1'b0;
      for (int i = 0; i < 40 && sv === 1'b1; i++) step();
    end
  endtask
  task wait_drv();
    for (int i = 0; i < 40 && drv !== 1'b1; i++) step();
  endtask
  task play();
    req = 1'b1;
    wait_drv();
    step();
    for (int k = 0; k < 8; k++) begin
      lv[k] = lvl;
      step(3);
    end
  endtask
  task halt();
    stp = 1'b1;
    step();
    stp = 1'b0;
    req = 1'b0;
    step(6);
  endtask
  task halflen();
    logic p, f;
    p = pol;
    for (int i = 0; i < 99 && pol === p; i++) step();
    p = pol;
    f = hpf;
    n = 0;
    h = 0;
    while (pol === p && n < 99) begin
      step();
      n++;
      if (hpf !== f) h++;
      f = hpf;
    end
  endtask
  ////////////////////////////////////////
  task t_shape();
    shape = 1'b1;
    hold = 1'b1;
    push(17);
    chk(sr, 1'b0);
    play();
    halt();
    chk(lv[0], 8'h00);
    for (int k = 1; k < 4; k++) begin
      chk(lv[k], lv[8-k]);
      chk(near(lv[k], lv[4], dc[k]), 1'b1);
    end
    chk({imph, impl}, sense);
    chk(vif, sense);
    chk(flags[2], 1'b1);
  endtask
  task t_coeff();
    for (int s = 1; s < 4; s++) begin
      csel = s[1:0];
      cwr = 1'b1;
      step();
      cwr = 1'b0;
      push(2);
      play();
      halt();
      chk(lv[s], 8'h00);
      chk(lv[8-s], 8'h00);
    end
  endtask
  task t_freeze();
    clr = 3'h7;
    step();
    clr = 3'h0;
    step();
    chk(flags, 3'h0);
    rcd = 1'b1;
    sense = 8'h3C;
    push(2);
    play();
    halt();
    chk(flags[2], 1'b0);
    chk({imph, impl}, 8'hA7);
    chk(vif, 8'hA7);
    rcd = 1'b0;
  endtask
  task t_loop();
    shape = 1'b0;
    push(2);
    play();
    halt();
    pk = peak();
    ale = 1'b1;
    bemf = 1'b1;
    push(2);
    play();
    halt();
    chk(near(peak(), pk, 8'hC0), 1'b1);
    ale = 1'b0;
    bemf = 1'b0;
  endtask
  task t_period();
    shape = 1'b1;
    req = 1'b1;
    step(450);
    halt();
    chk(sr, 1'b1);
    per = 16'h0020;
    for (int m = 3; m >= 0; m--) begin
      mode = m[1:0];
      has = m[1];
      push(4);
      req = 1'b1;
      wait_drv();
      if (m < 2) dper = 16'h0020;
      halflen();
      halflen();
      chk(n, 40);
      chk(h, 1);
      halt();
    end
  endtask
  task t_short();
    push(2);
    req = 1'b1;
    wait_drv();
    shrt = 1'b1;
    step(6);
    chk(drv, 1'b0);
    chk(lpe, 1'b0);
    chk(flags[0], 1'b1);
    chk(irq, 1'b1);
    mk1 = 3'h1;
    mk2 = 3'h6;
    step();
    chk(irq, 1'b0);
    mk1 = 3'h0;
    mk2 = 3'h0;
    shrt = 1'b0;
    req = 1'b0;
    step(4);
    clr = 3'h7;
    step();
    clr = 3'h0;
    step();
    chk(flags, 3'h0);
    emb = 1'b1;
    req = 1'b1;
    wait_drv();
    shrt = 1'b1;
    step(6);
    shrt = 1'b0;
    req = 1'b0;
    step(8);
    chk(flags, 3'h0);
    req = 1'b1;
    wait_drv();
    chk(drv, 1'b1);
    halt();
  endtask
  initial begin
    step(4);
    arst_n = 1'b1;
    step(2);
    chk(flags, 3'h0);
    chk(vif, 8'h40);
    t_shape();
    t_coeff();
    t_freeze();
    t_loop();
    t_period();
    t_short();
    close_out();
  end
endmodule // haptic_drive_advanced_modes_bench
